// ===== verilog/fusec_timer_pkg.sv
// Purpose: Constants for the free-running microsecond timer.
// Assumes: A 25 MHz system clock.
// Notes: Addresses are the processor's I/O port numbers.
package fusec_timer_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int ClkHz = 25_000_000;
  localparam int TickHz = 1_000_000;
  localparam int TickCycles = ClkHz / TickHz;
  localparam logic [4:0] TickLast = 5'(TickCycles - 1);
  // ----------------------------------------
  // Counter layout and addresses
  // ----------------------------------------
  localparam int CountWidth = 12;
  localparam int FastBit = 6;
  localparam int SlowBit = 9;
  localparam logic [7:0] AddrLow = 8'h24;
  localparam logic [7:0] AddrHigh = 8'h25;
  localparam logic [11:0] CountReset = 12'h000;
endpackage

// ===== verilog/fusec_timer.sv
// Purpose: Twelve-bit free-running microsecond timer with coherent two-part read.
// Assumes: Synchronous active-high reset; I/O read strobe synchronous to clk.
// Notes: Read data is registered and valid the cycle after the strobe.
module fusec_timer
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ioRead,
  input wire logic [7:0] ioAddr,
  input wire logic fastEnable,
  input wire logic slowEnable,
  output logic [7:0] readData,
  output logic fastIrq,
  output logic slowIrq
);
  import fusec_timer_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [4:0] prescale;
  logic [4:0] next_prescale;
  logic [11:0] count;
  logic [11:0] next_count;
  logic [3:0] heldHigh;
  logic [3:0] next_heldHigh;
  logic [7:0] next_readData;
  logic next_fastIrq;
  logic next_slowIrq;
  logic tick;
  logic lowRead;
  logic highRead;
  wire logic [1:0] srcRise;
  logic [4:0] tickGap;
  logic [4:0] next_tickGap;

  // ----------------------------------------
  // Microsecond prescaler
  // ----------------------------------------
  always_comb begin
    tick = (prescale == TickLast);
    next_prescale = prescale + 5'h01;
    if (tick) begin
      next_prescale = 5'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prescale <= 5'h00;
    end else begin
      prescale <= next_prescale;
    end
  end

  // ----------------------------------------
  // Free-running counter
  // ----------------------------------------
  always_comb begin
    next_count = count;
    if (tick) begin
      next_count = count + 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= CountReset;
    end else begin
      count <= next_count;
    end
  end

  // ----------------------------------------
  // Read port and holding register
  // ----------------------------------------
  always_comb begin
    lowRead = ioRead && (ioAddr == AddrLow);
    highRead = ioRead && (ioAddr == AddrHigh);
    next_heldHigh = heldHigh;
    next_readData = 8'h00;
    if (lowRead) begin
      next_heldHigh = count[11:8];
      next_readData = count[7:0];
    end else if (highRead) begin
      next_readData = {4'h0, heldHigh};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      heldHigh <= 4'h0;
      readData <= 8'h00;
    end else begin
      heldHigh <= next_heldHigh;
      readData <= next_readData;
    end
  end

  // ----------------------------------------
  // Periodic requests
  // ----------------------------------------
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : gen_request
      localparam int SrcBit = (ch == 0) ? FastBit : SlowBit;
      assign srcRise[ch] = next_count[SrcBit] && !count[SrcBit];
    end
  endgenerate

  always_comb begin
    next_fastIrq = fastEnable && srcRise[0];
    next_slowIrq = slowEnable && srcRise[1];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fastIrq <= 1'b0;
      slowIrq <= 1'b0;
    end else begin
      fastIrq <= next_fastIrq;
      slowIrq <= next_slowIrq;
    end
  end

  // ----------------------------------------
  // Check helper: cycles since the count last moved
  // ----------------------------------------
  always_comb begin
    next_tickGap = tickGap + 5'h01;
    if (next_count != count) begin
      next_tickGap = 5'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tickGap <= 5'h00;
    end else begin
      tickGap <= next_tickGap;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  tick_spacing_a: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(count) |=> ##23 !$changed(count))
    else $error("Tick spacing wrong.");

  tick_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(count) |-> $past(tickGap) == TickLast)
    else $error("Count moved off its tick.");

  gap_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
    tickGap <= TickLast)
    else $error("Count stalled.");

  count_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(count) |-> count == 12'($past(count) + 12'h001))
    else $error("Count step wrong.");

  fast_edge_a: assert property (@(posedge clk) disable iff (sys_rst)
    fastIrq |-> count[FastBit] && !$past(count[FastBit]))
    else $error("Fast irq no edge.");

  slow_edge_a: assert property (@(posedge clk) disable iff (sys_rst)
    slowIrq |-> count[SlowBit] && !$past(count[SlowBit]))
    else $error("Slow irq no edge.");

  fast_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
    fastIrq |-> $past(fastEnable))
    else $error("Disabled fast irq.");

  slow_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
    slowIrq |-> $past(slowEnable))
    else $error("Disabled slow irq.");

  fast_period_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(count[FastBit]) && $past(fastEnable) |-> fastIrq)
    else $error("Fast irq missed.");

  slow_period_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(count[SlowBit]) && $past(slowEnable) |-> slowIrq)
    else $error("Slow irq missed.");

  fast_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    fastIrq |=> !fastIrq)
    else $error("Fast irq too long.");

  slow_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    slowIrq |=> !slowIrq)
    else $error("Slow irq too long.");

  hold_capture_a: assert property (@(posedge clk) disable iff (sys_rst)
    lowRead |=> heldHigh == $past(count[11:8]))
    else $error("No capture.");

  hold_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    !lowRead |=> heldHigh == $past(heldHigh))
    else $error("Held bits moved.");

  high_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    highRead |=> readData == {4'h0, $past(heldHigh)})
    else $error("High read wrong.");

  low_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    lowRead |=> readData == $past(count[7:0]))
    else $error("Low read wrong.");

  idle_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    !lowRead && !highRead |=> readData == 8'h00)
    else $error("Stray read data.");
endmodule

// ===== verif/tb.sv
// Purpose: Self-checking bench for the microsecond timer.
// Assumes: 25 clocks per tick; count after n free edges is n / 25.
// Notes: Expected irq edges use the fast pulse as the phase reference.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic sys_rst = 1;
  logic ioRead = 0;
  logic fastEnable = 0;
  logic slowEnable = 1;
  logic [7:0] ioAddr = 8'h00;
  logic [7:0] readData;
  logic fastIrq;
  logic slowIrq;
  int cyc = 0;
  int num_errors = 0;
  int comparisons = 0;
  int t1 = 0;
  int t2 = 0;
  fusec_timer fusec_timer_inst (.clk(clk), .sys_rst(sys_rst), .ioRead(ioRead),
    .ioAddr(ioAddr), .fastEnable(fastEnable), .slowEnable(slowEnable),
    .readData(readData), .fastIrq(fastIrq), .slowIrq(slowIrq));
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    if (sys_rst) begin
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
    end
  end
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input int at);
    wait (cyc == at);
    #1 ioRead = 1;
    ioAddr = a;
    @(posedge clk);
    #1 ioRead = 0;
    chk(readData === e, "read data");
  endtask
  task automatic irq_at(input bit fast, input int lo, input int hi, output int n);
    n = -1;
    while (cyc <= hi && n < 0) begin
      @(posedge clk);
      #1 if ((fast ? fastIrq : slowIrq) === 1'b1) n = cyc;
    end
    chk(n >= lo && n <= hi, "irq timing");
  endtask
  task automatic test_done;
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic test_refused;
    rd(8'h26, 8'h00, 10);
  endtask
  task automatic test_masked;
    while (cyc < 3000) begin
      @(posedge clk);
      #1 chk(fastIrq === 1'b0, "masked irq");
    end
    fastEnable = 1;
  endtask
  task automatic test_first_edge;
    irq_at(1, 4800, 4802, t1);
  endtask
  task automatic test_two_part;
    rd(8'h24, 8'hFF, 6385);
    rd(8'h25, 8'h00, 6420);
  endtask
  task automatic test_periods;
    irq_at(1, t1 + 3200, t1 + 3200, t2);
    irq_at(0, t1 + 8000, t1 + 8000, t2);
    rd(8'h24, 8'h00, 12810);
    rd(8'h25, 8'h02, 12830);
  endtask
  task automatic test_reset;
    @(posedge clk);
    #1 sys_rst = 1;
    fastEnable = 0;
    slowEnable = 0;
    repeat (20) @(posedge clk);
    #1 sys_rst = 0;
    chk(readData === 8'h00, "reset read data");
    rd(8'h25, 8'h00, 20);
    rd(8'h24, 8'h01, 30);
    while (cyc < 13000) begin
      @(posedge clk);
      #1 chk(slowIrq === 1'b0 && fastIrq === 1'b0, "masked irqs");
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 sys_rst = 0;
    test_refused;
    test_masked;
    test_first_edge;
    test_two_part;
    test_periods;
    test_reset;
    test_done;
  end
  initial begin
    #1200000;
    num_errors++;
    test_done;
  end
endmodule
